// ### bench/fpmps_ctl_chk.sv
// assertion checker for the power mode and page size control
module fpmps_ctl_chk
	import fpmps_pkg::*;
#(
	parameter int unsigned CFG_PROG_TIME_NS = CFG_PROGRAM_TIME_NS
)
(
	input wire logic          i_sys_clk,
	input wire logic          i_nrst,
	input wire fpmps_status_t o_status,
	input wire logic          o_cmd_enable,
	input wire logic          o_deep_pd,
	input wire logic          o_ultra_pd,
	input wire logic          o_buffer_lost,
	input wire logic          o_nv_prog,
	input wire logic          o_nv_prog_256
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------
	// helper logic
	// ----------
	localparam int CFG_CYC = CFG_PROG_TIME_NS / CLK_PERIOD_NS;
	logic [15:0] prog_cnt_reg;
	logic [1:0]  age_reg;

	// program length, and age since reset so the size load is not a change
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			prog_cnt_reg <= 16'h0;
			age_reg      <= 2'h0;
		end else begin
			prog_cnt_reg <= o_nv_prog ? prog_cnt_reg + 16'h1 : 16'h0;
			if (age_reg != 2'h3) begin
				age_reg <= age_reg + 2'h1;
			end
		end
	end

	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);

	// ----------
	// properties
	// ----------
	property p_deep_alone;
		o_deep_pd |-> !o_ultra_pd && !o_cmd_enable;
	endproperty
	a_deep_alone: assert property (p_deep_alone) else $error("deep mixed");
	property p_ultra_alone;
		o_ultra_pd |-> !o_deep_pd && !o_cmd_enable;
	endproperty
	a_ultra_alone: assert property (p_ultra_alone) else $error("ultra mixed");
	property p_busy;
		o_nv_prog |-> !o_status.ready;
	endproperty
	a_busy: assert property (p_busy) else $error("ready in program");
	property p_prog_len;
		$fell(o_nv_prog) |-> prog_cnt_reg >= CFG_CYC && prog_cnt_reg <= CFG_CYC + 2;
	endproperty
	a_prog_len: assert property (p_prog_len) else $error("program length");
	property p_apply;
		$fell(o_nv_prog) |-> o_status.page_256 == $past(o_nv_prog_256);
	endproperty
	a_apply: assert property (p_apply) else $error("size not applied");
	property p_page_hold;
		age_reg == 2'h3 && $changed(o_status.page_256) |-> $fell(o_nv_prog);
	endproperty
	a_page_hold: assert property (p_page_hold) else $error("size moved");
	property p_lost;
		o_buffer_lost |=> o_ultra_pd && !o_buffer_lost;
	endproperty
	a_lost: assert property (p_lost) else $error("buffer loss pulse");
	property p_entry;
		$fell(o_cmd_enable) |-> ##[0:33] (o_deep_pd || o_ultra_pd || o_nv_prog);
	endproperty
	a_entry: assert property (p_entry) else $error("entry late");
	property p_resume_wait;
		$fell(o_deep_pd) |-> !o_cmd_enable [*8];
	endproperty
	a_resume_wait: assert property (p_resume_wait) else $error("resume early");
	property p_exit_wait;
		$fell(o_ultra_pd) |-> !o_cmd_enable [*8];
	endproperty
	a_exit_wait: assert property (p_exit_wait) else $error("exit early");
endmodule

bind fpmps_ctl fpmps_ctl_chk #(.CFG_PROG_TIME_NS(CFG_PROG_TIME_NS)) u_chk (.*);

// ### bench/fpmps_host_model.sv
// host side serial model: drives select, serial clock and data
module fpmps_host_model (
	output logic o_cs_n,
	output logic o_sck,
	output logic o_mosi
);
	timeunit 1ns;
	timeprecision 100ps;

	// idle: deselected, clock low and still
	initial begin
		o_cs_n = 1'b1;
		o_sck  = 1'b0;
		o_mosi = 1'b0;
	end

	// one frame, msb first, mode 0; clock only runs inside the frame
	task automatic send(input logic [31:0] data, input int nbits, input int low_ns);
		#17;
		o_cs_n = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			o_mosi = data[31 - i];
			#3 o_sck = 1'b1;
			#3 o_sck = 1'b0;
		end
		#(low_ns);
		o_cs_n = 1'b1;
		o_mosi = ~o_mosi; // released line keeps no stale value
	endtask
endmodule

// ### bench/test_flash_power_mode_page_size_ctl.sv
// self-checking bench for the power mode and page size control
module test_flash_power_mode_page_size_ctl
	import fpmps_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct {
		logic [31:0] data;
		int          nbits;
		int          mode;
	} fpmps_row_t;

	logic          i_sys_clk     = 1'b0;
	logic          i_nrst        = 1'b0;
	logic          i_op_busy     = 1'b0;
	logic          i_nv_blank    = 1'b1;
	logic          i_nv_page_256 = 1'b1;
	logic          cs_n;
	logic          sck;
	logic          mosi;
	fpmps_status_t o_status;
	logic          o_cmd_enable;
	logic          o_standby;
	logic          o_deep_pd;
	logic          o_ultra_pd;
	logic          o_buffer_lost;
	logic          o_nv_prog;
	logic          o_nv_prog_256;
	logic          exp_page      = 1'b0;
	logic [7:0]    exp_lost      = 8'h00;
	logic [7:0]    lost_count    = 8'h00;
	int            fail_count    = 0;
	int            samples_checked = 0;

	// mode: 0 nothing, 1 deep, 2 ultra, 3 size program
	fpmps_row_t rows [10] = '{
		'{{OPC_DEEP_ENTER, 24'h5A0000}, 16, 1},
		'{{OPC_DEEP_ENTER, 24'h0}, 7, 0},
		'{{OPC_ULTRA_ENTER, 24'h0}, 8, 2},
		'{{OPC_ULTRA_ENTER, 24'hF00000}, 12, 2},
		'{{OPC_ULTRA_ENTER, 24'h0}, 7, 0},
		'{{OPC_DEEP_RESUME, 24'h0}, 8, 0},
		'{{OPC_CFG_B0, OPC_CFG_B1, OPC_CFG_B2, OPC_CFG_256}, 32, 3},
		'{{OPC_CFG_B0, OPC_CFG_B1, OPC_CFG_B2, OPC_CFG_264}, 32, 3},
		'{{OPC_CFG_B0, OPC_CFG_B1, OPC_CFG_B2, OPC_CFG_256}, 32, 3},
		'{{OPC_CFG_B0, OPC_CFG_B1, OPC_CFG_B2, OPC_CFG_264}, 31, 0}
	};

	// ----------
	// design, host and clock
	// ----------
	fpmps_ctl #(.CFG_PROG_TIME_NS(2000), .FACTORY_PAGE_256(1'b0)) DUT (
		.i_sys_clk     (i_sys_clk),
		.i_nrst        (i_nrst),
		.i_ce          (1'b1),
		.i_sck         (sck),
		.i_cs_n        (cs_n),
		.i_mosi        (mosi),
		.i_op_busy     (i_op_busy),
		.i_nv_blank    (i_nv_blank),
		.i_nv_page_256 (i_nv_page_256),
		.o_status      (o_status),
		.o_cmd_enable  (o_cmd_enable),
		.o_standby     (o_standby),
		.o_deep_pd     (o_deep_pd),
		.o_ultra_pd    (o_ultra_pd),
		.o_buffer_lost (o_buffer_lost),
		.o_nv_prog     (o_nv_prog),
		.o_nv_prog_256 (o_nv_prog_256)
	);
	fpmps_host_model host (.o_cs_n(cs_n), .o_sck(sck), .o_mosi(mosi));

	initial begin
		forever #50 i_sys_clk = ~i_sys_clk;
	end

	// nonvolatile cell: takes the value while programming, survives reset
	always @(posedge i_sys_clk) begin
		if (o_nv_prog) begin
			i_nv_blank    <= 1'b0;
			i_nv_page_256 <= o_nv_prog_256;
		end
		// one-cycle loss notice is too short to poll, so count it
		if (o_buffer_lost) begin
			lost_count <= lost_count + 8'h01;
		end
	end

	// ----------
	// helpers
	// ----------
	task automatic wcyc(input int n);
		repeat (n) @(posedge i_sys_clk);
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		samples_checked++;
		if (seen !== want) begin
			fail_count++;
			$display("ERROR %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// hang guard, well past the expected run
	initial begin
		#3000000;
		fail_count++;
		wrap_up();
	end

	// ----------
	// tests
	// ----------
	initial begin
		wcyc(6);
		i_nrst <= 1'b1;
		wcyc(4);
		check(o_status.page_256, 1'b0);
		check(o_standby, 1'b1);
		// table rows; few size writes keep wear low
		foreach (rows[r]) begin
			host.send(rows[r].data, rows[r].nbits, 200);
			wcyc(10);
			if (rows[r].mode == 3) begin
				check(o_nv_prog, 1'b1);
				check(o_status.ready, 1'b0);
				exp_page = (rows[r].data[7:0] == OPC_CFG_256);
			end
			wcyc(40);
			if (rows[r].mode == 2) begin
				exp_lost++;
			end
			check(lost_count, exp_lost);
			check(o_deep_pd, rows[r].mode == 1);
			check(o_ultra_pd, rows[r].mode == 2);
			check(o_status.page_256, exp_page);
			if (rows[r].mode == 1) begin
				host.send({OPC_DEEP_RESUME, 24'h0}, 8, 200);
				wcyc(400);
			end else if (rows[r].mode == 2) begin
				host.send(32'h0, 8, 25000);
				wcyc(1300);
			end
			check(o_status.ready, 1'b1);
			check(o_cmd_enable, 1'b1);
		end
		// deep ignores other commands and a partial resume
		host.send({OPC_DEEP_ENTER, 24'h0}, 8, 200);
		wcyc(50);
		host.send({OPC_ULTRA_ENTER, 24'h0}, 8, 200);
		wcyc(50);
		host.send({OPC_CFG_B0, OPC_CFG_B1, OPC_CFG_B2, OPC_CFG_264}, 32, 200);
		wcyc(50);
		host.send({OPC_DEEP_RESUME, 24'h0}, 7, 200);
		wcyc(400);
		check(o_deep_pd, 1'b1);
		check(o_status.page_256, exp_page);
		host.send({OPC_DEEP_RESUME, 24'h0}, 8, 200);
		wcyc(300);
		check(o_cmd_enable, 1'b0);
		wcyc(100);
		check(o_cmd_enable, 1'b1);
		// ultra: short pulse with resume opcode does not wake it
		host.send({OPC_ULTRA_ENTER, 24'h0}, 8, 200);
		wcyc(50);
		host.send({OPC_DEEP_RESUME, 24'h0}, 8, 200);
		wcyc(50);
		check(o_ultra_pd, 1'b1);
		host.send(32'h0, 8, 25000);
		wcyc(300);
		check(o_ultra_pd, 1'b0);
		host.send({OPC_DEEP_ENTER, 24'h0}, 8, 200);
		wcyc(1000);
		check(o_deep_pd, 1'b0);
		check(o_cmd_enable, 1'b1);
		// entry refused while an array operation runs
		i_op_busy <= 1'b1;
		host.send({OPC_DEEP_ENTER, 24'h0}, 8, 200);
		wcyc(50);
		check(o_deep_pd, 1'b0);
		i_op_busy <= 1'b0;
		wcyc(4);
		host.send({OPC_DEEP_ENTER, 24'h0}, 8, 200);
		wcyc(50);
		check(o_deep_pd, 1'b1);
		// reset in deep: back to standby, size kept
		i_nrst <= 1'b0;
		wcyc(6);
		i_nrst <= 1'b1;
		wcyc(5);
		check(o_deep_pd, 1'b0);
		check(o_cmd_enable, 1'b1);
		check(o_status.page_256, exp_page);
		wrap_up();
	end
endmodule

// ### design/fpmps_ctl.sv
// power mode and page size command control of a serial flash
// Summary of operation
// - idle select and no operation means standby
// - opcode B9h then select high enters deep
// - deep ignores everything except the resume opcode
// - bits after a complete opcode are ignored
// - partial entry opcode aborts back to standby
// - power up always lands in standby
// - entry requests ignored while an operation runs
// - opcode ABh resumes to standby after delay
// - partial resume opcode stays in deep
// - opcode 79h then select high enters ultra
// - ultra ignores all commands including resume
// - ultra entry leaves the buffer undefined
// - select low pulse wakes ultra, byte ignored
// - commands ignored until ultra exit time passes
// - four byte sequence selects 256 or 264
// - select high starts timed program, shows busy
// - new size applies when programming completes
// - size held nonvolatile, switchable both ways
// - blank part defaults to 264 byte pages
// - status msb is zero busy, one ready
// - status lsb is one for 256 bytes
module fpmps_ctl
	import fpmps_pkg::*;
#(
	parameter int unsigned CFG_PROG_TIME_NS = CFG_PROGRAM_TIME_NS,
	parameter logic        FACTORY_PAGE_256 = 1'b0
)
(
	input  wire logic          i_sys_clk,
	input  wire logic          i_nrst,
	input  wire logic          i_ce,
	input  wire logic          i_sck,
	input  wire logic          i_cs_n,
	input  wire logic          i_mosi,
	input  wire logic          i_op_busy,
	input  wire logic          i_nv_blank,
	input  wire logic          i_nv_page_256,
	output fpmps_status_t      o_status,
	output logic               o_cmd_enable,
	output logic               o_standby,
	output logic               o_deep_pd,
	output logic               o_ultra_pd,
	output logic               o_buffer_lost,
	output logic               o_nv_prog,
	output logic               o_nv_prog_256
);

	// ------------------------------------------------------------
	// timing counts
	// ------------------------------------------------------------
	localparam int unsigned CFG_PROG_CYC_I =
		fpmps_atleast1(CFG_PROG_TIME_NS / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] CFG_PROG_CYC    = TMR_W'(CFG_PROG_CYC_I);
	localparam logic [TMR_W-1:0] DEEP_ENTRY_C    = TMR_W'(DEEP_ENTRY_CYC);
	localparam logic [TMR_W-1:0] DEEP_RESUME_C   = TMR_W'(DEEP_RESUME_CYC);
	localparam logic [TMR_W-1:0] ULTRA_ENTRY_C   = TMR_W'(ULTRA_ENTRY_CYC);
	localparam logic [TMR_W-1:0] ULTRA_EXIT_C    = TMR_W'(ULTRA_EXIT_CYC);
	localparam logic [TMR_W-1:0] WAKE_PULSE_C    = TMR_W'(WAKE_PULSE_CYC);
	localparam logic [TMR_W-1:0] TMR_ONE         = TMR_W'(1);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	fpmps_frame_t         link_frame;
	logic                 link_tog;
	logic                 cs_meta_reg;
	logic                 cs_sync_reg;
	logic                 cs_prev_reg;
	logic                 tog_meta_reg;
	logic                 tog_sync_reg;
	logic                 tog_ref_reg;
	logic                 eval_reg;
	logic                 frame_ok_reg;
	logic                 cs_rise;
	logic                 cs_fall;
	fpmps_state_t         state_reg;
	fpmps_state_t         state_next;
	logic [TMR_W-1:0]     tmr_reg;
	logic [TMR_W-1:0]     low_cnt_reg;
	logic                 page_256_reg;
	logic                 pend_256_reg;
	logic                 nv_load_reg;
	logic                 busy_any;
	logic [2:0]           nb;
	logic                 cmd_deep;
	logic                 cmd_resume;
	logic                 cmd_ultra;
	logic                 cmd_cfg;
	logic                 cfg_sel_256;
	logic                 tmr_done;
	logic                 wake_ok;

	// timer expiry test, shared by every timed state
	function automatic logic fpmps_expired(input logic [TMR_W-1:0] cnt,
	                                       input logic [TMR_W-1:0] lim);
		return (cnt >= lim - TMR_ONE);
	endfunction

	// ------------------------------------------------------------
	// serial clock receiver
	// ------------------------------------------------------------
	fpmps_link u_link (
		.i_sck   (i_sck),
		.i_nrst  (i_nrst),
		.i_cs_n  (i_cs_n),
		.i_mosi  (i_mosi),
		.o_frame (link_frame),
		.o_tog   (link_tog)
	);

	// ------------------------------------------------------------
	// crossings into the system clock
	// ------------------------------------------------------------
	// select and the frame toggle each pass two flip-flops
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cs_meta_reg  <= 1'b1;
			cs_sync_reg  <= 1'b1;
			cs_prev_reg  <= 1'b1;
			tog_meta_reg <= 1'b0;
			tog_sync_reg <= 1'b0;
		end else if (i_ce) begin
			cs_meta_reg  <= i_cs_n;
			cs_sync_reg  <= cs_meta_reg;
			cs_prev_reg  <= cs_sync_reg;
			tog_meta_reg <= link_tog;
			tog_sync_reg <= tog_meta_reg;
		end
	end

	assign cs_rise = cs_sync_reg & ~cs_prev_reg;
	assign cs_fall = ~cs_sync_reg & cs_prev_reg;

	// ------------------------------------------------------------
	// frame bookkeeping
	// ------------------------------------------------------------
	// decode waits one cycle after select rises so the toggle, which
	// moved before select did, has surely reached its synchroniser end;
	// the frame bytes are still by then since the serial clock stopped
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			eval_reg     <= 1'b0;
			tog_ref_reg  <= 1'b0;
			frame_ok_reg <= 1'b0;
		end else if (i_ce) begin
			eval_reg <= cs_rise;
			if (eval_reg) begin
				tog_ref_reg <= tog_sync_reg;
			end
			// a frame begun during a wake-up or entry is dead from the start
			if (cs_fall) begin
				frame_ok_reg <= (state_reg == ST_STANDBY) || (state_reg == ST_DEEP);
			end
		end
	end

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	// whole bytes only: a frame with no complete byte decodes as nothing
	assign nb = (tog_sync_reg != tog_ref_reg) ? link_frame.nbytes : 3'h0;
	// one full opcode is enough, trailing bits do not matter
	assign cmd_deep   = (nb >= NB_OPCODE) && (link_frame.b0 == OPC_DEEP_ENTER);
	assign cmd_resume = (nb >= NB_OPCODE) && (link_frame.b0 == OPC_DEEP_RESUME);
	assign cmd_ultra  = (nb >= NB_OPCODE) && (link_frame.b0 == OPC_ULTRA_ENTER);
	assign cmd_cfg    = (nb >= NB_CFG) && (link_frame.b0 == OPC_CFG_B0)
	                    && (link_frame.b1 == OPC_CFG_B1) && (link_frame.b2 == OPC_CFG_B2)
	                    && ((link_frame.b3 == OPC_CFG_256)
	                        || (link_frame.b3 == OPC_CFG_264));
	assign cfg_sel_256 = (link_frame.b3 == OPC_CFG_256);

	// any self-timed work in progress
	assign busy_any = i_op_busy || (state_reg == ST_CFG_PROG);

	// ------------------------------------------------------------
	// timer and wake pulse width
	// ------------------------------------------------------------
	// one timer serves all states; it restarts on every state change
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tmr_reg <= '0;
		end else if (i_ce) begin
			if (state_next != state_reg) begin
				tmr_reg <= '0;
			end else if (tmr_reg != '1) begin
				tmr_reg <= tmr_reg + TMR_ONE;
			end
		end
	end

	// counts how long select has been low while in ultra power-down
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			low_cnt_reg <= '0;
		end else if (i_ce) begin
			if (cs_sync_reg || state_reg != ST_ULTRA) begin
				low_cnt_reg <= '0;
			end else if (low_cnt_reg != '1) begin
				low_cnt_reg <= low_cnt_reg + TMR_ONE;
			end
		end
	end

	// low time held at the rising edge, any dummy byte is never decoded
	assign wake_ok = cs_rise && (low_cnt_reg >= WAKE_PULSE_C);

	always_comb begin
		tmr_done = 1'b0;
		unique case (state_reg)
			ST_DEEP_ENTRY:  tmr_done = fpmps_expired(tmr_reg, DEEP_ENTRY_C);
			ST_DEEP_RESUME: tmr_done = fpmps_expired(tmr_reg, DEEP_RESUME_C);
			ST_ULTRA_ENTRY: tmr_done = fpmps_expired(tmr_reg, ULTRA_ENTRY_C);
			ST_ULTRA_EXIT:  tmr_done = fpmps_expired(tmr_reg, ULTRA_EXIT_C);
			ST_CFG_PROG:    tmr_done = fpmps_expired(tmr_reg, CFG_PROG_CYC);
			ST_STANDBY, ST_DEEP, ST_ULTRA: tmr_done = 1'b0;
			default:        tmr_done = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// power mode state machine
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_STANDBY: begin
				// entry asked during program or erase is simply dropped
				if (eval_reg && frame_ok_reg && !busy_any) begin
					if (cmd_deep) begin
						state_next = ST_DEEP_ENTRY;
					end else if (cmd_ultra) begin
						state_next = ST_ULTRA_ENTRY;
					end else if (cmd_cfg) begin
						state_next = ST_CFG_PROG;
					end
				end
				// a short frame matches nothing, so standby holds
			end
			ST_DEEP_ENTRY: begin
				if (tmr_done) begin
					state_next = ST_DEEP;
				end
			end
			ST_DEEP: begin
				// only a complete resume opcode gets through
				if (eval_reg && frame_ok_reg && cmd_resume) begin
					state_next = ST_DEEP_RESUME;
				end
			end
			ST_DEEP_RESUME: begin
				if (tmr_done) begin
					state_next = ST_STANDBY;
				end
			end
			ST_ULTRA_ENTRY: begin
				if (tmr_done) begin
					state_next = ST_ULTRA;
				end
			end
			ST_ULTRA: begin
				// frames are never decoded here, resume included
				if (wake_ok) begin
					state_next = ST_ULTRA_EXIT;
				end
			end
			ST_ULTRA_EXIT: begin
				if (tmr_done) begin
					state_next = ST_STANDBY;
				end
			end
			ST_CFG_PROG: begin
				if (tmr_done) begin
					state_next = ST_STANDBY;
				end
			end
			default: begin
				state_next = ST_STANDBY;
			end
		endcase
	end

	// power-up and reset land in standby, never a power-down state
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_reg <= ST_STANDBY;
		end else if (i_ce) begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------
	// page size selection
	// ------------------------------------------------------------
	// the stored size is loaded once after reset release, since the
	// nonvolatile cell outlives power cycles; a blank cell means the
	// factory setting, 264 bytes unless built otherwise
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			nv_load_reg  <= 1'b1;
			page_256_reg <= 1'b0;
			pend_256_reg <= 1'b0;
		end else if (i_ce) begin
			if (nv_load_reg) begin
				nv_load_reg  <= 1'b0;
				page_256_reg <= i_nv_blank ? FACTORY_PAGE_256 : i_nv_page_256;
			end else if (state_reg == ST_CFG_PROG && tmr_done) begin
				page_256_reg <= pend_256_reg;
			end
			// either direction is accepted, no lock on the setting
			if (state_reg == ST_STANDBY && state_next == ST_CFG_PROG) begin
				pend_256_reg <= cfg_sel_256;
			end
		end
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_status      <= '0;
			o_cmd_enable  <= 1'b0;
			o_standby     <= 1'b0;
			o_deep_pd     <= 1'b0;
			o_ultra_pd    <= 1'b0;
			o_buffer_lost <= 1'b0;
			o_nv_prog     <= 1'b0;
			o_nv_prog_256 <= 1'b0;
		end else if (i_ce) begin
			// status follows the next state, so busy, the program strobe
			// and the new size all change on the same edge
			o_status.ready    <= ~(i_op_busy || state_next == ST_CFG_PROG);
			o_status.page_256 <= (state_reg == ST_CFG_PROG && tmr_done)
			                     ? pend_256_reg : page_256_reg;
			// other command logic may run only from standby
			o_cmd_enable  <= (state_reg == ST_STANDBY);
			o_standby     <= (state_reg == ST_STANDBY) && cs_sync_reg && !busy_any;
			o_deep_pd     <= (state_reg == ST_DEEP);
			o_ultra_pd    <= (state_reg == ST_ULTRA);
			// one-cycle notice that buffer contents are gone
			o_buffer_lost <= (state_reg == ST_ULTRA_ENTRY) && tmr_done;
			o_nv_prog     <= (state_next == ST_CFG_PROG);
			o_nv_prog_256 <= (state_next == ST_CFG_PROG) ? ((state_reg == ST_CFG_PROG)
			                 ? pend_256_reg : cfg_sel_256) : 1'b0;
		end
	end

endmodule

// ### design/fpmps_link.sv
// serial-clock side receiver: counts bits and keeps the first bytes of a frame
module fpmps_link
	import fpmps_pkg::*;
(
	input  wire logic         i_sck,
	input  wire logic         i_nrst,
	input  wire logic         i_cs_n,
	input  wire logic         i_mosi,
	output fpmps_frame_t      o_frame,
	output logic              o_tog
);

	logic [BIT_CNT_W-1:0] bit_cnt_reg;
	logic [6:0]           shift_reg;
	fpmps_frame_t         frame_reg;
	logic                 tog_reg;
	logic [7:0]           byte_now;
	logic [2:0]           byte_idx;

	assign byte_now = {shift_reg, i_mosi};
	assign byte_idx = bit_cnt_reg[5:3];
	assign o_frame  = frame_reg;
	assign o_tog    = tog_reg;

	// ------------------------------------------------------------
	// bit counter, cleared while select is high
	// ------------------------------------------------------------
	// select high holds it at zero, so each frame counts from its first bit
	always_ff @(posedge i_sck or posedge i_cs_n) begin
		if (i_cs_n) begin
			bit_cnt_reg <= '0;
		end else if (bit_cnt_reg != BIT_CNT_MAX) begin
			bit_cnt_reg <= bit_cnt_reg + 6'h01;
		end
	end

	// ------------------------------------------------------------
	// shifter and captured bytes
	// ------------------------------------------------------------
	// results live on the serial clock and stay put after the frame;
	// the system side reads them only once select has risen
	always_ff @(posedge i_sck or negedge i_nrst) begin
		if (!i_nrst) begin
			shift_reg <= '0;
			frame_reg <= '0;
			tog_reg   <= 1'b0;
		end else if (!i_cs_n) begin
			shift_reg <= byte_now[6:0]; // msb first
			if (bit_cnt_reg == '0) begin
				tog_reg          <= ~tog_reg; // marks a frame with bits
				frame_reg.nbytes <= '0;
			end
			// bytes past the fourth are dropped
			if (bit_cnt_reg != BIT_CNT_MAX && bit_cnt_reg[2:0] == BIT_LAST) begin
				frame_reg.nbytes <= byte_idx + 3'h1;
				unique case (byte_idx)
					3'h0: frame_reg.b0 <= byte_now;
					3'h1: frame_reg.b1 <= byte_now;
					3'h2: frame_reg.b2 <= byte_now;
					3'h3: frame_reg.b3 <= byte_now;
					default: frame_reg.b3 <= frame_reg.b3;
				endcase
			end
		end
	end

endmodule

// ### design/fpmps_pkg.sv
// package of constants and types for the flash power mode and page size control
package fpmps_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS        = 100;
	localparam int unsigned DEEP_ENTRY_TIME_NS   = 3000;
	localparam int unsigned DEEP_RESUME_TIME_NS  = 35000;
	localparam int unsigned ULTRA_ENTRY_TIME_NS  = 3000;
	localparam int unsigned WAKE_PULSE_MIN_NS    = 20000;
	localparam int unsigned ULTRA_EXIT_TIME_NS   = 120000;
	localparam int unsigned CFG_PROGRAM_TIME_NS  = 4000000;

	// never less than one cycle
	function automatic int unsigned fpmps_atleast1(input int unsigned n);
		return (n == 0) ? 1 : n;
	endfunction

	// longest times round down, least times round up
	localparam int unsigned DEEP_ENTRY_CYC  = fpmps_atleast1(DEEP_ENTRY_TIME_NS / CLK_PERIOD_NS);
	localparam int unsigned DEEP_RESUME_CYC = fpmps_atleast1(DEEP_RESUME_TIME_NS / CLK_PERIOD_NS);
	localparam int unsigned ULTRA_ENTRY_CYC = fpmps_atleast1(ULTRA_ENTRY_TIME_NS / CLK_PERIOD_NS);
	localparam int unsigned ULTRA_EXIT_CYC  = fpmps_atleast1(ULTRA_EXIT_TIME_NS / CLK_PERIOD_NS);
	localparam int unsigned WAKE_PULSE_CYC  =
		fpmps_atleast1((WAKE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	localparam int unsigned TMR_W = 16;

	// ----------------------------------------------------------------
	// serial framing
	// ----------------------------------------------------------------
	localparam int unsigned BIT_CNT_W   = 6;
	localparam logic [5:0]  BIT_CNT_MAX = 6'h20;
	localparam logic [2:0]  BIT_LAST    = 3'h7;
	localparam logic [2:0]  NB_OPCODE   = 3'h1;
	localparam logic [2:0]  NB_CFG      = 3'h4;

	// ----------------------------------------------------------------
	// opcodes
	// ----------------------------------------------------------------
	localparam logic [7:0] OPC_DEEP_ENTER  = 8'hB9;
	localparam logic [7:0] OPC_DEEP_RESUME = 8'hAB;
	localparam logic [7:0] OPC_ULTRA_ENTER = 8'h79;
	localparam logic [7:0] OPC_CFG_B0      = 8'h3D;
	localparam logic [7:0] OPC_CFG_B1      = 8'h2A;
	localparam logic [7:0] OPC_CFG_B2      = 8'h80;
	localparam logic [7:0] OPC_CFG_256     = 8'hA6;
	localparam logic [7:0] OPC_CFG_264     = 8'hA7;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_STANDBY     = 4'h0,
		ST_DEEP_ENTRY  = 4'h1,
		ST_DEEP        = 4'h2,
		ST_DEEP_RESUME = 4'h3,
		ST_ULTRA_ENTRY = 4'h4,
		ST_ULTRA       = 4'h5,
		ST_ULTRA_EXIT  = 4'h6,
		ST_CFG_PROG    = 4'h7
	} fpmps_state_t;

	// bytes seen in one frame, first byte in b0
	typedef struct packed {
		logic [2:0] nbytes;
		logic [7:0] b0;
		logic [7:0] b1;
		logic [7:0] b2;
		logic [7:0] b3;
	} fpmps_frame_t;

	// status bits owned by this block
	typedef struct packed {
		logic ready;
		logic page_256;
	} fpmps_status_t;

endpackage
